/* File: common/ivp_arb_if.sv */
// request/level bundle between the register block and the arbiter
// assumes one clock domain, purely combinational signals
`timescale 1ns/1ps
interface ivp_arb_if #(parameter int N = ivp_pkg::NSRC);
   logic [N-1:0] req;
   logic [N-1:0][ivp_pkg::LVL_W-1:0] lvl;
   logic [ivp_pkg::IDX_W-1:0] win;
   logic [ivp_pkg::LVL_W-1:0] win_lvl;
   logic win_vld;
   modport src (output req, output lvl, input win, input win_lvl, input win_vld);
   modport arb (input req, input lvl, output win, output win_lvl, output win_vld);
endinterface : ivp_arb_if

/* File: common/ivp_pkg.sv */
// constants of the interrupt vector and priority block
// assumes a 32-bit apb slave at 50 mhz, registers one aligned word each
package ivp_pkg;
   localparam int ADDR_W = 8;
   localparam int PRIO_W = 4;
   localparam int LVL_W = 5;
   localparam int VEC_W = 8;
   localparam int IDX_W = 4;
   localparam int NSRC = 15;
   // register byte addresses
   localparam logic [7:0] A_ICTRL = 8'h00;
   localparam logic [7:0] A_PRA = 8'h04;
   localparam logic [7:0] A_PRB = 8'h08;
   localparam logic [7:0] A_PRC = 8'h0C;
   localparam logic [7:0] A_VBASE = 8'h10;
   localparam logic [7:0] A_VDMA0 = 8'h14;
   localparam logic [7:0] A_VDMA1 = 8'h18;
   localparam logic [7:0] A_VWDT = 8'h1C;
   localparam logic [7:0] A_VA = 8'h20;
   localparam logic [7:0] A_VRSVD = 8'h24;
   localparam logic [7:0] A_VC = 8'h28;
   localparam logic [7:0] A_VD = 8'h2C;
   localparam logic [7:0] A_EVST = 8'h30;
   localparam logic [7:0] A_EVEN = 8'h34;
   localparam logic [7:0] A_EVCLR = 8'h38;
   localparam logic [7:0] A_CUR = 8'h3C;
   localparam logic [7:0] A_ETHEN = 8'h40;
   localparam logic [7:0] A_MACEN = 8'h44;
   // control bits
   localparam int ICTRL_MODE = 0;
   localparam int ICTRL_EXTV = 1;
   localparam int EV_ACCEPT = 0;
   localparam int EV_EXTERR = 1;
   // field positions and write masks
   localparam int PRA_DMA_LSB = 8;
   localparam int PRA_WDOG_LSB = 4;
   localparam int PRB_ETH_LSB = 12;
   localparam int PRB_FRT_LSB = 8;
   localparam int PRC_PIN0_LSB = 12;
   localparam int VCR_HI_LSB = 8;
   localparam logic [15:0] PRA_WMASK = 16'h0FF0;
   localparam logic [15:0] PRB_WMASK = 16'hFF00;
   localparam logic [15:0] PRC_WMASK = 16'hFFFF;
   localparam logic [15:0] VCR_WMASK = 16'h7F7F;
   localparam logic [15:0] VCR_LO_WMASK = 16'h007F;
   localparam logic [15:0] PRIO_RST = 16'h0000;
   localparam int ETH_FLAGS = 19;
   localparam int MAC_FLAGS = 3;
   localparam int COPY_BIT = 0;
   // fixed vectors and levels
   localparam logic [7:0] VEC_NMI = 8'h0B;
   localparam logic [7:0] VEC_UBRK = 8'h0C;
   localparam logic [7:0] VEC_DBG = 8'h0D;
   localparam logic [7:0] VEC_PIN0 = 8'h40;
   localparam logic [7:0] VEC_EXT_MAX = 8'h7F;
   localparam logic [4:0] LVL_NMI = 5'h10;
   localparam logic [4:0] LVL_BRK = 5'h0F;
   // source indices, in default order, highest first
   localparam logic [3:0] SRC_NMI = 4'h0;
   localparam logic [3:0] SRC_UBRK = 4'h1;
   localparam logic [3:0] SRC_DBG = 4'h2;
   localparam logic [3:0] SRC_PIN0 = 4'h3;
   localparam logic [3:0] SRC_PIN3 = 4'h6;
   localparam logic [3:0] SRC_DMA0 = 4'h7;
   localparam logic [3:0] SRC_DMA1 = 4'h8;
   localparam logic [3:0] SRC_WDOG = 4'h9;
   localparam logic [3:0] SRC_REF = 4'hA;
   localparam logic [3:0] SRC_ETH = 4'hB;
   localparam logic [3:0] SRC_ICI = 4'hC;
   localparam logic [3:0] SRC_OCI = 4'hD;
   localparam logic [3:0] SRC_OVI = 4'hE;
endpackage : ivp_pkg

/* File: design/ivp_arb.sv */
// highest-level-wins arbiter, ties go to the lowest index
// assumes sources are indexed in default priority order
`timescale 1ns/1ps
module ivp_arb #(
   parameter int N = ivp_pkg::NSRC
) (
   ivp_arb_if.arb bus // requests in, winner out
);
   import ivp_pkg::*;
   always_comb begin
      bus.win = '0;
      bus.win_lvl = '0;
      bus.win_vld = 1'b0;
      // R07 tie keeps first listed
      for (int i = 0; i < N; i++) begin
         if (bus.req[i] && (!bus.win_vld || bus.lvl[i] > bus.win_lvl)) begin
            bus.win = IDX_W'(i);
            bus.win_lvl = bus.lvl[i];
            bus.win_vld = 1'b1;
         end
      end
   end
endmodule : ivp_arb

/* File: design/ivp_top.sv */
// interrupt vector and priority resolution, individual-pin mode
// assumes level requests synchronous to pclk, cpu acks with a one-cycle pulse
//
// Notes on behaviour
// R01: external vector fetch allowed, only vectors 0 to 127 accepted.
// R02: peripheral vectors come from programmable seven-bit fields, high or low half.
// R03: mode bit picks encoded levels or four individual request pins; the code has no encoded-level input, mode 1 only masks the pins.
// R04: software must not access the reserved vector slot after ethernet's.
// R05: ethernet request is OR of enabled 19 flags plus copied mac flags.
// R06: nmi 11 at 16, break 12 and debug 13 at 15, pins 64-67 programmable.
// R07: table address is base plus vector times four; ties by default order.
// R08: priority registers sixteen bits, read/write, reset to zero.
// R09: both dma channels share a level; channel 0 wins ties.
// R10: watchdog and refresh share a level; watchdog wins ties.
`timescale 1ns/1ps
module ivp_top (
   input wire logic pclk, // 50 mhz clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [ivp_pkg::ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic nmi_req, // nonmaskable request
   input wire logic ubrk_req, // user break request
   input wire logic debug_port_irq, // debug port request
   input wire logic [3:0] individual_request_pins, // external pins, high active
   input wire logic [1:0] dma_req, // dma channel 0 and 1
   input wire logic wdog_req, // watchdog interval
   input wire logic ref_req, // refresh compare match
   input wire logic [2:0] frt_req, // timer capture, compare, overflow
   input wire logic [ivp_pkg::ETH_FLAGS-1:0] ether_dma_status, // dma status flags
   input wire logic [ivp_pkg::MAC_FLAGS-1:0] mac_status, // mac status flags
   input wire logic [ivp_pkg::VEC_W-1:0] ext_vec, // vector from outside
   input wire logic [ivp_pkg::PRIO_W-1:0] cpu_mask, // cpu mask level
   input wire logic irq_ack, // cpu accepts request
   output logic irq_req, // request to cpu
   output logic [ivp_pkg::LVL_W-1:0] irq_level, // winning level
   output logic [ivp_pkg::VEC_W-1:0] irq_vector, // winning vector
   output logic [31:0] irq_addr, // vector table address
   output logic ether_dma_irq, // ethernet combined request
   output logic irq_out // status interrupt
);
   import ivp_pkg::*;

   typedef struct packed {
      logic [1:0] ictrl;
      logic [15:0] pra;
      logic [15:0] prb;
      logic [15:0] prc;
      logic [31:0] vbase;
      logic [15:0] vdma0;
      logic [15:0] vdma1;
      logic [15:0] vwdt;
      logic [15:0] va;
      logic [15:0] vc;
      logic [15:0] vd;
      logic [ETH_FLAGS-1:0] eth_en;
      logic [MAC_FLAGS-1:0] mac_en;
      logic [1:0] ev_st;
      logic [1:0] ev_en;
      logic req;
      logic [LVL_W-1:0] lvl;
      logic [VEC_W-1:0] vec;
      logic [31:0] addr;
      logic [31:0] rdata;
      logic err;
   } ivp_st_s;

   ivp_st_s st_r, st_nxt;
   ivp_arb_if #(.N(NSRC)) arb_bus ();
   logic [ETH_FLAGS-1:0] eth_flags;
   logic [VEC_W-1:0] auto_vec;
   logic ext_bad;
   logic wr_acc;
   logic rd_setup;
   logic addr_ok;

   ivp_arb #(.N(NSRC)) u_arb (.bus(arb_bus.arb));

   function automatic logic [LVL_W-1:0] lvl_of(input logic [15:0] r, input int lsb);
      lvl_of = {1'b0, r[lsb +: PRIO_W]};
   endfunction : lvl_of

   always_comb begin
      // R05 mac flags fold into the copy bit
      eth_flags = ether_dma_status;
      eth_flags[COPY_BIT] = ether_dma_status[COPY_BIT] | (|(mac_status & st_r.mac_en));
      ether_dma_irq = |(eth_flags & st_r.eth_en);
   end

   always_comb begin
      arb_bus.req = '0;
      arb_bus.lvl = '0;
      // R06 fixed sources and levels
      arb_bus.req[SRC_NMI] = nmi_req;
      arb_bus.lvl[SRC_NMI] = LVL_NMI;
      arb_bus.req[SRC_UBRK] = ubrk_req;
      arb_bus.lvl[SRC_UBRK] = LVL_BRK;
      arb_bus.req[SRC_DBG] = debug_port_irq;
      arb_bus.lvl[SRC_DBG] = LVL_BRK;
      for (int i = 0; i < 4; i++) begin
         // R03 pins ignored in encoded-level mode
         arb_bus.req[int'(SRC_PIN0) + i] = individual_request_pins[i] & ~st_r.ictrl[ICTRL_MODE];
         arb_bus.lvl[int'(SRC_PIN0) + i] = lvl_of(st_r.prc, PRC_PIN0_LSB - 4 * i);
      end
      // R09 shared dma level, channel 0 listed first
      arb_bus.req[SRC_DMA0] = dma_req[0];
      arb_bus.req[SRC_DMA1] = dma_req[1];
      arb_bus.lvl[SRC_DMA0] = lvl_of(st_r.pra, PRA_DMA_LSB);
      arb_bus.lvl[SRC_DMA1] = lvl_of(st_r.pra, PRA_DMA_LSB);
      // R10 shared level, watchdog listed first
      arb_bus.req[SRC_WDOG] = wdog_req;
      arb_bus.req[SRC_REF] = ref_req;
      arb_bus.lvl[SRC_WDOG] = lvl_of(st_r.pra, PRA_WDOG_LSB);
      arb_bus.lvl[SRC_REF] = lvl_of(st_r.pra, PRA_WDOG_LSB);
      arb_bus.req[SRC_ETH] = ether_dma_irq;
      arb_bus.lvl[SRC_ETH] = lvl_of(st_r.prb, PRB_ETH_LSB);
      for (int i = 0; i < 3; i++) begin
         arb_bus.req[int'(SRC_ICI) + i] = frt_req[i];
         arb_bus.lvl[int'(SRC_ICI) + i] = lvl_of(st_r.prb, PRB_FRT_LSB);
      end
   end

   always_comb begin
      // R02 programmable vector fields
      unique case (arb_bus.win)
         SRC_NMI: auto_vec = VEC_NMI;
         SRC_UBRK: auto_vec = VEC_UBRK;
         SRC_DBG: auto_vec = VEC_DBG;
         SRC_DMA0: auto_vec = {1'b0, st_r.vdma0[6:0]};
         SRC_DMA1: auto_vec = {1'b0, st_r.vdma1[6:0]};
         SRC_WDOG: auto_vec = {1'b0, st_r.vwdt[VCR_HI_LSB +: 7]};
         SRC_REF: auto_vec = {1'b0, st_r.vwdt[6:0]};
         SRC_ETH: auto_vec = {1'b0, st_r.va[VCR_HI_LSB +: 7]};
         SRC_ICI: auto_vec = {1'b0, st_r.vc[VCR_HI_LSB +: 7]};
         SRC_OCI: auto_vec = {1'b0, st_r.vc[6:0]};
         SRC_OVI: auto_vec = {1'b0, st_r.vd[VCR_HI_LSB +: 7]};
         default: auto_vec = VEC_PIN0 + VEC_W'(arb_bus.win - SRC_PIN0);
      endcase
   end

   assign wr_acc = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;

   always_comb begin
      unique case (paddr)
         A_ICTRL, A_PRA, A_PRB, A_PRC, A_VBASE, A_VDMA0, A_VDMA1, A_VWDT, A_VA, A_VC, A_VD,
         A_EVST, A_EVEN, A_EVCLR, A_CUR, A_ETHEN, A_MACEN: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   always_comb begin
      logic pin_win;
      logic wr;
      logic [1:0] ev_set;
      pin_win = 1'b0;
      wr = 1'b0;
      ev_set = '0;
      st_nxt = st_r;
      wr = wr_acc & addr_ok;
      pin_win = arb_bus.win >= SRC_PIN0 && arb_bus.win <= SRC_PIN3;
      // R01 out-of-range external vector falls back to auto vector
      ext_bad = pin_win & st_r.ictrl[ICTRL_EXTV] & (ext_vec > VEC_EXT_MAX);
      st_nxt.req = arb_bus.win_vld && (arb_bus.win_lvl > {1'b0, cpu_mask});
      st_nxt.lvl = arb_bus.win_lvl;
      st_nxt.vec = (pin_win && st_r.ictrl[ICTRL_EXTV] && !ext_bad) ? ext_vec : auto_vec;
      // R07 table address
      st_nxt.addr = st_r.vbase + {22'h0, st_nxt.vec, 2'b00};
      ev_set[EV_ACCEPT] = irq_ack & st_r.req;
      ev_set[EV_EXTERR] = ext_bad & arb_bus.win_vld;
      if (wr) begin
         unique case (paddr)
            A_ICTRL: st_nxt.ictrl = pwdata[1:0];
            // R08 priority registers written in place
            A_PRA: st_nxt.pra = pwdata[15:0] & PRA_WMASK;
            A_PRB: st_nxt.prb = pwdata[15:0] & PRB_WMASK;
            A_PRC: st_nxt.prc = pwdata[15:0] & PRC_WMASK;
            A_VBASE: st_nxt.vbase = pwdata;
            A_VDMA0: st_nxt.vdma0 = pwdata[15:0] & VCR_LO_WMASK;
            A_VDMA1: st_nxt.vdma1 = pwdata[15:0] & VCR_LO_WMASK;
            A_VWDT: st_nxt.vwdt = pwdata[15:0] & VCR_WMASK;
            A_VA: st_nxt.va = pwdata[15:0] & VCR_WMASK;
            A_VC: st_nxt.vc = pwdata[15:0] & VCR_WMASK;
            A_VD: st_nxt.vd = pwdata[15:0] & VCR_WMASK;
            A_EVEN: st_nxt.ev_en = pwdata[1:0];
            A_EVCLR: st_nxt.ev_st = st_r.ev_st & ~pwdata[1:0];
            A_ETHEN: st_nxt.eth_en = pwdata[ETH_FLAGS-1:0];
            A_MACEN: st_nxt.mac_en = pwdata[MAC_FLAGS-1:0];
            default: ;
         endcase
      end
      // set beats a clear in the same cycle
      st_nxt.ev_st = st_nxt.ev_st | ev_set;
      if (rd_setup) begin
         // R04 reserved slot and holes answer with an error
         st_nxt.err = ~addr_ok;
         unique case (paddr)
            A_ICTRL: st_nxt.rdata = {30'h0, st_r.ictrl};
            A_PRA: st_nxt.rdata = {16'h0, st_r.pra};
            A_PRB: st_nxt.rdata = {16'h0, st_r.prb};
            A_PRC: st_nxt.rdata = {16'h0, st_r.prc};
            A_VBASE: st_nxt.rdata = st_r.vbase;
            A_VDMA0: st_nxt.rdata = {16'h0, st_r.vdma0};
            A_VDMA1: st_nxt.rdata = {16'h0, st_r.vdma1};
            A_VWDT: st_nxt.rdata = {16'h0, st_r.vwdt};
            A_VA: st_nxt.rdata = {16'h0, st_r.va};
            A_VC: st_nxt.rdata = {16'h0, st_r.vc};
            A_VD: st_nxt.rdata = {16'h0, st_r.vd};
            A_EVST: st_nxt.rdata = {30'h0, st_r.ev_st};
            A_EVEN: st_nxt.rdata = {30'h0, st_r.ev_en};
            A_CUR: st_nxt.rdata = {18'h0, st_r.req, st_r.lvl, st_r.vec};
            A_ETHEN: st_nxt.rdata = {13'h0, st_r.eth_en};
            A_MACEN: st_nxt.rdata = {29'h0, st_r.mac_en};
            default: st_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         // R08 priorities clear on reset
         st_r.pra <= PRIO_RST;
         st_r.prb <= PRIO_RST;
         st_r.prc <= PRIO_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdata;
   assign pready = 1'b1;
   assign pslverr = st_r.err & psel & penable;
   assign irq_req = st_r.req;
   assign irq_level = st_r.lvl;
   assign irq_vector = st_r.vec;
   assign irq_addr = st_r.addr;
   assign irq_out = |(st_r.ev_st & st_r.ev_en);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence apb_wr_s(logic [7:0] a);
      psel && !penable && pwrite && paddr == a ##1 psel && penable;
   endsequence
   sequence only_pin_s(int i);
      individual_request_pins == 4'(1 << i) && !nmi_req && !ubrk_req && !debug_port_irq
         && dma_req == 2'b00 && !wdog_req && !ref_req && frt_req == 3'b000 && !ether_dma_irq;
   endsequence

   nmi_vector_a: assert property (nmi_req |=> irq_req && irq_vector == VEC_NMI // R06
      && irq_level == LVL_NMI) else $error("nmi not presented");
   pin_auto_a: assert property (only_pin_s(2) && !st_r.ictrl[ICTRL_MODE] // R06
      && !st_r.ictrl[ICTRL_EXTV] |=> irq_vector == VEC_PIN0 + 8'h02)
      else $error("pin vector wrong");
   pin_mode_a: assert property (st_r.ictrl[ICTRL_MODE] |-> !(arb_bus.win_vld // R03
      && arb_bus.win >= SRC_PIN0 && arb_bus.win <= SRC_PIN3))
      else $error("pin served in encoded mode");
   ext_range_a: assert property (irq_req |-> irq_vector <= VEC_EXT_MAX) // R01
      else $error("vector above range");
   table_addr_a: assert property (irq_req && $stable(st_r.vbase) |-> // R07
      irq_addr == st_r.vbase + {22'h0, irq_vector, 2'b00}) else $error("bad table address");
   prio_write_a: assert property (apb_wr_s(A_PRC) |=> st_r.prc == $past(pwdata[15:0])) // R08
      else $error("prio write lost");
   dma_tie_a: assert property (dma_req == 2'b11 && arb_bus.win_vld // R09
      && arb_bus.win >= SRC_DMA0 && arb_bus.win <= SRC_DMA1 |-> arb_bus.win == SRC_DMA0)
      else $error("dma tie wrong");
   wdog_tie_a: assert property (wdog_req && ref_req && arb_bus.win_vld // R10
      && arb_bus.win >= SRC_WDOG && arb_bus.win <= SRC_REF |-> arb_bus.win == SRC_WDOG)
      else $error("refresh beat watchdog");
   dma_vec_a: assert property (arb_bus.win_vld && arb_bus.win == SRC_DMA0 |=> // R02
      irq_vector == {1'b0, $past(st_r.vdma0[6:0])}) else $error("dma vector wrong");
   eth_or_a: assert property ((ether_dma_status & st_r.eth_en) != '0 |-> ether_dma_irq) // R05
      else $error("ethernet request missing");
   rsvd_slot_a: assert property (psel && !penable && paddr == A_VRSVD |=> pslverr) // R04
      else $error("reserved slot accepted");
endmodule : ivp_top

/* File: tb/irq_mode_vector_priority_tb_top.sv */
// self-checking bench of the vector and priority block
// assumes the cpu model on the ack side and a 50 mhz pclk
`timescale 1ns/1ps
module irq_mode_vector_priority_tb_top;
   import ivp_pkg::*;
   typedef struct {int sel; logic [32:0] exp; string what;} ivp_note_s;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, ext_vec = 8'h00, rnd = 8'h38;
   logic [31:0] pwdata = 32'h0, prdata, irq_addr, vb;
   logic pready, pslverr, irq_req, ether_dma_irq, irq_out, irq_ack;
   logic nmi_req = 1'b0, ubrk_req = 1'b0, dbg_req = 1'b0, wdog_req = 1'b0, ref_req = 1'b0;
   logic [3:0] pins = 4'h0, cpu_mask = 4'h0, ack_wait = 4'h0;
   logic [1:0] dma_req = 2'h0;
   logic [2:0] frt_req = 3'h0, mac_st = 3'h0;
   logic [18:0] eth_st = 19'h0;
   logic [4:0] irq_level;
   logic [7:0] irq_vector;
   logic ack_on = 1'b0, look = 1'b0;
   logic [32:0] mon_seen;
   ivp_note_s exp_q[$];
   ivp_note_s mon_n;
   int bad_count = 0, checks = 0, n;

   always #10 pclk = ~pclk;

   ivp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .nmi_req(nmi_req), .ubrk_req(ubrk_req), .debug_port_irq(dbg_req),
      .individual_request_pins(pins), .dma_req(dma_req), .wdog_req(wdog_req),
      .ref_req(ref_req), .frt_req(frt_req), .ether_dma_status(eth_st), .mac_status(mac_st),
      .ext_vec(ext_vec), .cpu_mask(cpu_mask), .irq_ack(irq_ack), .irq_req(irq_req),
      .irq_level(irq_level), .irq_vector(irq_vector), .irq_addr(irq_addr),
      .ether_dma_irq(ether_dma_irq), .irq_out(irq_out));

   ivp_cpu_model cpu (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .ack_on(ack_on),
      .ack_wait(ack_wait), .irq_ack(irq_ack));

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop;
      if (bad_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   // read notes are taken in the access phase, matched at the pready edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] exp, input string what);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      if (!wr) begin
         exp_q.push_back('{0, exp, what});
         look <= 1'b1;
      end
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      look <= 1'b0;
      if (k >= 50) begin
         bad_count++;
         report_and_stop();
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0, "");
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [32:0] exp, input string what);
      apb(1'b0, a, 32'h0, exp, what);
   endtask : rd

   // request path answers one edge after its inputs; the check samples on the third edge
   task automatic out_chk(input int sel, input logic [32:0] exp, input string what);
      repeat (2) @(posedge pclk);
      exp_q.push_back('{sel, exp, what});
      look <= 1'b1;
      @(posedge pclk);
      look <= 1'b0;
   endtask : out_chk

   always @(posedge pclk) begin
      if (look && exp_q.size() > 0 && (exp_q[0].sel != 0 || (penable && pready === 1'b1))) begin
         mon_n = exp_q.pop_front();
         case (mon_n.sel)
            0: mon_seen = {pslverr, prdata};
            1: mon_seen = {19'h0, irq_req, irq_level, irq_vector};
            2: mon_seen = {1'b0, irq_addr};
            3: mon_seen = {32'h0, ether_dma_irq};
            4: mon_seen = {32'h0, irq_out};
            default: mon_seen = {32'h0, irq_req};
         endcase
         check(mon_n.what, mon_seen, mon_n.exp);
      end
   end

   initial begin
      repeat (100000) @(posedge pclk);
      bad_count++;
      report_and_stop();
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_PRA, 33'h0, "pra reset");
      rd(A_PRB, 33'h0, "prb reset");
      rd(A_PRC, 33'h0, "prc reset");
      wr(A_PRA, 32'hFFFFFFFF);
      rd(A_PRA, {17'h0, PRA_WMASK}, "pra mask");
      rnd = lfsr(rnd);
      wr(A_PRC, {16'h0, rnd, ~rnd});
      rd(A_PRC, {17'h0, rnd, ~rnd}, "prc rw");
      wr(A_VWDT, 32'hFFFF);
      rd(A_VWDT, {17'h0, VCR_WMASK}, "vcr fields");
      wr(A_VRSVD, 32'hFFFF);
      rd(A_VRSVD, 33'h100000000, "reserved slot");
      rd(8'h50, 33'h100000000, "unmapped");
      rnd = lfsr(rnd);
      vb = {rnd, ~rnd, rnd, 8'h00};
      wr(A_VBASE, vb);
      nmi_req <= 1'b1;
      out_chk(1, {20'h1, LVL_NMI, VEC_NMI}, "nmi");
      out_chk(2, {1'b0, vb + 32'h2C}, "nmi addr");
      nmi_req <= 1'b0;
      ubrk_req <= 1'b1;
      dbg_req <= 1'b1;
      out_chk(1, {20'h1, LVL_BRK, VEC_UBRK}, "break tie");
      ubrk_req <= 1'b0;
      out_chk(1, {20'h1, LVL_BRK, VEC_DBG}, "debug");
      dbg_req <= 1'b0;
      wr(A_PRC, 32'h4567);
      for (int i = 0; i < 4; i++) begin
         pins <= 4'h1 << i;
         out_chk(1, {20'h1, 5'(4 + i), VEC_PIN0 + 8'(i)}, "pin");
      end
      pins <= 4'hF;
      cpu_mask <= 4'h7;
      out_chk(1, {20'h0, 5'h07, 8'h43}, "masked pin");
      cpu_mask <= 4'h0;
      wr(A_PRC, 32'h5555);
      out_chk(1, {20'h1, 5'h05, VEC_PIN0}, "pin tie");
      wr(A_ICTRL, 32'h2);
      rnd = lfsr(rnd);
      ext_vec <= {1'b0, rnd[6:0]};
      out_chk(1, {20'h1, 5'h05, 1'b0, rnd[6:0]}, "ext vector");
      ext_vec <= {1'b1, rnd[6:0]};
      out_chk(1, {20'h1, 5'h05, VEC_PIN0}, "ext out of range");
      rd(A_EVST, 33'h2, "ext error event");
      wr(A_ICTRL, 32'h1);
      out_chk(5, 33'h0, "pins ignored");
      wr(A_ICTRL, 32'h0);
      pins <= 4'h0;
      wr(A_PRA, 32'h0930);
      wr(A_VDMA0, 32'h21);
      wr(A_VDMA1, 32'h22);
      dma_req <= 2'b11;
      out_chk(1, {20'h1, 5'h09, 8'h21}, "dma tie");
      dma_req <= 2'b10;
      out_chk(2, {1'b0, vb + 32'h88}, "dma1 addr");
      dma_req <= 2'b00;
      wr(A_VWDT, 32'h3132);
      wdog_req <= 1'b1;
      ref_req <= 1'b1;
      out_chk(1, {20'h1, 5'h03, 8'h31}, "watchdog tie");
      wdog_req <= 1'b0;
      out_chk(1, {20'h1, 5'h03, 8'h32}, "ref low field");
      ref_req <= 1'b0;
      eth_st <= 19'h7FFFF;
      out_chk(3, 33'h0, "eth disabled");
      wr(A_ETHEN, 32'h40000);
      eth_st <= 19'h3FFFF;
      out_chk(3, 33'h0, "eth other flags");
      eth_st <= 19'h40000;
      out_chk(3, 33'h1, "eth flag");
      wr(A_PRB, 32'h2000);
      wr(A_VA, 32'h4500);
      out_chk(1, {20'h1, 5'h02, 8'h45}, "eth vector");
      eth_st <= 19'h0;
      wr(A_ETHEN, 32'h1);
      wr(A_MACEN, 32'h4);
      mac_st <= 3'b011;
      out_chk(3, 33'h0, "mac masked");
      mac_st <= 3'b100;
      out_chk(3, 33'h1, "mac copy");
      mac_st <= 3'b000;
      wr(A_PRB, 32'h0400);
      wr(A_VC, 32'h5152);
      wr(A_VD, 32'h5300);
      frt_req <= 3'b111;
      out_chk(1, {20'h1, 5'h04, 8'h51}, "frt capture");
      frt_req <= 3'b110;
      out_chk(1, {20'h1, 5'h04, 8'h52}, "frt compare");
      frt_req <= 3'b100;
      out_chk(1, {20'h1, 5'h04, 8'h53}, "frt overflow");
      frt_req <= 3'b000;
      // slow then prompt cpu; the accept event is masked, then enabled
      for (int k = 0; k < 2; k++) begin
         wr(A_EVCLR, 32'h3);
         wr(A_EVEN, 32'h0);
         ack_wait <= (k == 0) ? 4'h5 : 4'h0;
         ack_on <= 1'b1;
         nmi_req <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (irq_ack !== 1'b1 && n < 50);
         ack_on <= 1'b0;
         nmi_req <= 1'b0;
         if (n >= 50) begin
            bad_count++;
            report_and_stop();
         end
         out_chk(4, 33'h0, "event masked");
         rd(A_EVST, 33'h1, "accept event");
         wr(A_EVEN, 32'h1);
         out_chk(4, 33'h1, "event enabled");
         wr(A_EVCLR, 32'h1);
         out_chk(4, 33'h0, "event cleared");
      end
      // written priorities must clear on a mid-run reset
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_PRC, 33'h0, "prc after reset");
      rd(A_PRA, 33'h0, "pra after reset");
      report_and_stop();
   end
endmodule : irq_mode_vector_priority_tb_top

/* File: tb/ivp_cpu_model.sv */
// cpu side model: accepts a raised request with a one-cycle ack pulse
// assumes irq_req is a registered level in the pclk domain
`timescale 1ns/1ps
module ivp_cpu_model (
   input wire logic pclk, // bench clock
   input wire logic presetn, // async reset, active low
   input wire logic irq_req, // request from block
   input wire logic ack_on, // accept requests at all
   input wire logic [3:0] ack_wait, // cycles before accepting
   output logic irq_ack // one-cycle accept pulse
);
   logic [3:0] cnt_r;
   // a slow cpu leaves the request standing for ack_wait cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
         irq_ack <= 1'b0;
      end else begin
         irq_ack <= 1'b0;
         if (!(ack_on && irq_req) || irq_ack) begin
            cnt_r <= 4'h0;
         end else if (cnt_r >= ack_wait) begin
            irq_ack <= 1'b1;
            cnt_r <= 4'h0;
         end else begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule : ivp_cpu_model
